// >>> hdl/test_packet_gen.sv
// Notes on behaviour
// - Fixed mode fills payload with fill byte from config bits 15:8.
// - Mode 0 incrementing, 1 fixed fill byte, 2 and 3 pseudo-random.
// - Config bits 5:3 give valid pattern bytes per packet, at most six.
// - Burst code 0..6 sends 1 to 1000000 packets; code 7 runs continuously.
// - Generator config resets to 5511h.
// - 48-bit pattern in three 16-bit words, low word first, reset zero.
// - 48-bit destination match value compared against received frame address.
// - Done status bit rises after the last burst packet and its FCS is sent, not after a stop.
// - Busy status bit shows that the generator is running.
//
// Local design decision: register access over APB.
`default_nettype none
module test_packet_gen #(
	parameter int PKT_BYTES = tpg_pkg::PKT_BYTES_DEF,
	parameter int GAP_CYCLES = tpg_pkg::GAP_CYCLES_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Generated transmit byte stream
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_first,
	output logic tx_last,
	input wire logic tx_ready,
	// Received byte stream for address match
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic [7:0] rx_data,
	output logic da_done,
	output logic da_match,
	// Generator state
	output logic gen_busy,
	output logic gen_done
);
	byte_step_if bs ();

	fcs_crc u_crc (
		.pclk(pclk),
		.presetn(presetn),
		.bs(bs.crc_unit)
	);

	prbs_bytes u_prbs (
		.pclk(pclk),
		.presetn(presetn),
		.bs(bs.prbs_unit)
	);

	tpg_pkg::gen_state_e state_reg;
	tpg_pkg::gen_state_e state_next;
	logic [15:0] cfg_reg;
	logic [15:0] words_reg [0:tpg_pkg::NUM_WORDS-1];
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic tx_valid_reg;
	logic [7:0] tx_data_reg;
	logic tx_first_reg;
	logic tx_last_reg;
	logic [15:0] byte_idx_reg;
	logic [1:0] fcs_idx_reg;
	logic [15:0] gap_cnt_reg;
	logic [19:0] remain_reg;
	logic cont_reg;
	logic stop_reg;
	logic busy_reg;
	logic done_reg;
	logic [2:0] rx_idx_reg;
	logic rx_active_reg;
	logic rx_ok_reg;
	logic da_done_reg;
	logic da_match_reg;
	logic match_seen_reg;

	// APB decode; read data is captured in the setup cycle, answer in the first access cycle
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & pready_reg;
	wire [15:0] idx = {2'b00, paddr[15:2]};
	wire aligned = paddr[1:0] == 2'b00;
	wire hit_cfg = aligned & (idx == tpg_pkg::IDX_GEN_CFG);
	wire hit_ctrl = aligned & (idx == tpg_pkg::IDX_GEN_CTRL);
	wire hit_stat = aligned & (idx == tpg_pkg::IDX_GEN_STATUS);
	logic [tpg_pkg::NUM_WORDS-1:0] hit_word;
	logic [15:0] rd_term [0:tpg_pkg::NUM_WORDS-1];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	// Pattern and match words share one layout, low word at the lowest index
	for (genvar k = 0; k < tpg_pkg::NUM_WORDS; k++) begin : g_word
		assign hit_word[k] = aligned & (idx == tpg_pkg::IDX_PAT_LOW + 16'(k));
		assign rd_term[k] = {16{hit_word[k]}} & words_reg[k];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				words_reg[k] <= tpg_pkg::WORD_RESET;
			end else if (wr_en && hit_word[k]) begin
				words_reg[k] <= merge(words_reg[k], pwdata, pstrb);
			end
		end
	end

	wire [15:0] status_word = {3'h0, done_reg, busy_reg, 10'h000, match_seen_reg};
	logic [15:0] rd_word;
	always_comb begin
		rd_word = ({16{hit_cfg}} & cfg_reg) | ({16{hit_stat}} & status_word);
		for (int k = 0; k < tpg_pkg::NUM_WORDS; k++) begin
			rd_word = rd_word | rd_term[k];
		end
	end
	wire mapped = hit_cfg | hit_ctrl | hit_stat | (|hit_word);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup) begin
				prdata_reg <= {16'h0000, rd_word};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= tpg_pkg::GEN_CFG_RESET;
		end else if (wr_en && hit_cfg) begin
			cfg_reg <= merge(cfg_reg, pwdata, pstrb);
		end
	end

	// Configuration fields
	wire [7:0] fill = cfg_reg[tpg_pkg::FILL_LSB +: 8];
	wire [1:0] mode = cfg_reg[tpg_pkg::MODE_LSB +: 2];
	wire [2:0] vld_raw = cfg_reg[tpg_pkg::VLD_LSB +: 3];
	wire [2:0] burst = cfg_reg[tpg_pkg::BURST_LSB +: 3];
	wire [2:0] vld = (vld_raw > tpg_pkg::VLD_MAX) ? tpg_pkg::VLD_MAX : vld_raw;

	// Byte selection for the next data byte
	wire [47:0] pat_flat = {words_reg[2], words_reg[1], words_reg[0]};
	wire [47:0] pat_shift = pat_flat >> {byte_idx_reg[2:0], 3'b000};
	wire in_pattern = byte_idx_reg < {13'h0000, vld};
	wire [7:0] pay_idx = 8'(byte_idx_reg - {13'h0000, vld});
	wire use_prbs = mode[1];
	wire [7:0] pay_byte = (mode == tpg_pkg::MODE_INC) ? pay_idx :
		(mode == tpg_pkg::MODE_FIXED) ? fill : bs.prbs;
	wire [7:0] next_byte = in_pattern ? pat_shift[7:0] : pay_byte;
	wire [31:0] fcs_val = ~bs.crc;
	wire [31:0] fcs_shift = fcs_val >> {fcs_idx_reg, 3'b000};

	// Output register is free when empty or being taken
	wire can_load = ~tx_valid_reg | tx_ready;
	wire load_data = (state_reg == tpg_pkg::GEN_DATA) & can_load;
	wire load_fcs = (state_reg == tpg_pkg::GEN_FCS) & can_load;
	wire last_data = byte_idx_reg == 16'(PKT_BYTES - 1);
	wire start = wr_en & hit_ctrl & pstrb[0] & pwdata[tpg_pkg::CTRL_START_BIT]
		& (state_reg == tpg_pkg::GEN_IDLE);
	wire stop = wr_en & hit_ctrl & pstrb[0] & pwdata[tpg_pkg::CTRL_STOP_BIT];
	// The final FCS byte has left once the output register is empty in the gap
	wire gap_free = (state_reg == tpg_pkg::GEN_GAP) & ~tx_valid_reg;
	wire last_pkt = stop_reg | (~cont_reg & (remain_reg == 20'h00001));
	wire finish = gap_free & last_pkt;
	wire restart = gap_free & ~last_pkt & (gap_cnt_reg == 16'(GAP_CYCLES - 1));

	assign bs.init_crc = start | restart;
	assign bs.init_prbs = start;
	assign bs.step_crc = load_data;
	assign bs.step_prbs = load_data & ~in_pattern & use_prbs;
	assign bs.data_in = next_byte;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			tpg_pkg::GEN_IDLE: begin
				if (start) begin
					state_next = tpg_pkg::GEN_DATA;
				end
			end
			tpg_pkg::GEN_DATA: begin
				if (load_data && last_data) begin
					state_next = tpg_pkg::GEN_FCS;
				end
			end
			tpg_pkg::GEN_FCS: begin
				if (load_fcs && fcs_idx_reg == tpg_pkg::FCS_LAST) begin
					state_next = tpg_pkg::GEN_GAP;
				end
			end
			tpg_pkg::GEN_GAP: begin
				if (finish) begin
					state_next = tpg_pkg::GEN_IDLE;
				end else if (restart) begin
					state_next = tpg_pkg::GEN_DATA;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= tpg_pkg::GEN_IDLE;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			busy_reg <= state_next != tpg_pkg::GEN_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_idx_reg <= 16'h0000;
			fcs_idx_reg <= 2'h0;
			gap_cnt_reg <= 16'h0000;
		end else begin
			if (start || restart) begin
				byte_idx_reg <= 16'h0000;
			end else if (load_data) begin
				byte_idx_reg <= byte_idx_reg + 16'h0001;
			end
			if (load_data) begin
				fcs_idx_reg <= 2'h0;
			end else if (load_fcs) begin
				fcs_idx_reg <= fcs_idx_reg + 2'h1;
			end
			if (gap_free) begin
				gap_cnt_reg <= gap_cnt_reg + 16'h0001;
			end else begin
				gap_cnt_reg <= 16'h0000;
			end
		end
	end

	// Burst accounting; stop ends the burst after the current packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain_reg <= 20'h00000;
			cont_reg <= 1'b0;
			stop_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			if (start) begin
				cont_reg <= burst == tpg_pkg::BURST_CONT;
				remain_reg <= (burst == tpg_pkg::BURST_CONT) ? 20'h00000 :
					tpg_pkg::BURST_COUNT[burst];
			end else if (restart && !cont_reg) begin
				remain_reg <= remain_reg - 20'h00001;
			end
			if (start || finish) begin
				stop_reg <= 1'b0;
			end else if (stop && busy_reg) begin
				stop_reg <= 1'b1;
			end
			if (finish && !stop_reg) begin
				done_reg <= 1'b1;
			end else if (start) begin
				done_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			tx_first_reg <= 1'b0;
			tx_last_reg <= 1'b0;
		end else if (load_data) begin
			tx_valid_reg <= 1'b1;
			tx_data_reg <= next_byte;
			tx_first_reg <= byte_idx_reg == 16'h0000;
			tx_last_reg <= 1'b0;
		end else if (load_fcs) begin
			tx_valid_reg <= 1'b1;
			tx_data_reg <= fcs_shift[7:0];
			tx_first_reg <= 1'b0;
			tx_last_reg <= fcs_idx_reg == tpg_pkg::FCS_LAST;
		end else if (tx_ready) begin
			tx_valid_reg <= 1'b0;
		end
	end

	// Destination address compare, first received byte against bits 7:0
	wire [47:0] dm_flat = {words_reg[5], words_reg[4], words_reg[3]};
	wire [2:0] rx_idx = rx_sof ? 3'h0 : rx_idx_reg;
	wire [47:0] dm_shift = dm_flat >> {rx_idx, 3'b000};
	wire rx_eq = rx_data == dm_shift[7:0];
	wire rx_take = rx_valid & (rx_sof | rx_active_reg);
	wire rx_end = rx_take & (rx_idx == tpg_pkg::DA_LAST);
	wire rx_ok = (rx_sof | rx_ok_reg) & rx_eq;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_idx_reg <= 3'h0;
			rx_active_reg <= 1'b0;
			rx_ok_reg <= 1'b0;
			da_done_reg <= 1'b0;
			da_match_reg <= 1'b0;
			match_seen_reg <= 1'b0;
		end else begin
			da_done_reg <= rx_end;
			da_match_reg <= rx_end & rx_ok;
			if (rx_take) begin
				rx_idx_reg <= rx_idx + 3'h1;
				rx_active_reg <= ~rx_end;
				rx_ok_reg <= rx_ok;
			end
			if (rx_end) begin
				match_seen_reg <= rx_ok;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx_valid = tx_valid_reg;
	assign tx_data = tx_data_reg;
	assign tx_first = tx_first_reg;
	assign tx_last = tx_last_reg;
	assign da_done = da_done_reg;
	assign da_match = da_match_reg;
	assign gen_busy = busy_reg;
	assign gen_done = done_reg;
endmodule : test_packet_gen
`default_nettype wire

// >>> hdl/tpg_pkg.sv
`default_nettype none
package tpg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_GEN_CFG = 16'h0624;
	localparam logic [15:0] IDX_PAT_LOW = 16'h0625;
	localparam logic [15:0] IDX_PAT_MID = 16'h0626;
	localparam logic [15:0] IDX_PAT_HIGH = 16'h0627;
	localparam logic [15:0] IDX_DM_LOW = 16'h0628;
	localparam logic [15:0] IDX_DM_MID = 16'h0629;
	localparam logic [15:0] IDX_DM_HIGH = 16'h062A;
	localparam logic [15:0] IDX_GEN_CTRL = 16'h062B;
	localparam logic [15:0] IDX_GEN_STATUS = 16'h062C;
	localparam int NUM_WORDS = 6;
	// Configuration fields and reset values
	localparam logic [15:0] GEN_CFG_RESET = 16'h5511;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int FILL_LSB = 8;
	localparam int MODE_LSB = 6;
	localparam int VLD_LSB = 3;
	localparam int BURST_LSB = 0;
	localparam logic [1:0] MODE_INC = 2'h0;
	localparam logic [1:0] MODE_FIXED = 2'h1;
	localparam logic [2:0] VLD_MAX = 3'h6;
	localparam logic [2:0] BURST_CONT = 3'h7;
	localparam logic [19:0] BURST_COUNT [0:6] = '{20'h00001, 20'h0000A, 20'h00064,
		20'h003E8, 20'h02710, 20'h186A0, 20'hF4240};
	// Control and status bits
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int ST_DONE_BIT = 12;
	localparam int ST_BUSY_BIT = 11;
	localparam int ST_MATCH_BIT = 0;
	// Frame shape and checksum
	localparam int PKT_BYTES_DEF = 60;
	localparam int GAP_CYCLES_DEF = 12;
	localparam logic [1:0] FCS_LAST = 2'h3;
	localparam logic [2:0] DA_LAST = 3'h5;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [14:0] PRBS_SEED = 15'h7FFF;
	typedef enum logic [1:0] {
		GEN_IDLE = 2'h0,
		GEN_DATA = 2'h1,
		GEN_FCS = 2'h3,
		GEN_GAP = 2'h2
	} gen_state_e;
endpackage : tpg_pkg
`default_nettype wire

// >>> hdl/byte_step_if.sv
`default_nettype none
interface byte_step_if;
	logic init_crc;
	logic init_prbs;
	logic step_crc;
	logic step_prbs;
	logic [7:0] data_in;
	logic [31:0] crc;
	logic [7:0] prbs;
	modport ctrl (output init_crc, init_prbs, step_crc, step_prbs, data_in, input crc, prbs);
	modport crc_unit (input init_crc, step_crc, data_in, output crc);
	modport prbs_unit (input init_prbs, step_prbs, output prbs);
endinterface : byte_step_if
`default_nettype wire

// >>> hdl/fcs_crc.sv
`default_nettype none
module fcs_crc (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Byte steps
	byte_step_if.crc_unit bs
);
	logic [31:0] crc_reg;
	logic [31:0] crc_next;

	// Reflected byte-wise update, LSB of each byte first
	always_comb begin
		crc_next = crc_reg ^ {24'h000000, bs.data_in};
		for (int i = 0; i < 8; i++) begin
			crc_next = crc_next[0] ? ((crc_next >> 1) ^ tpg_pkg::CRC_POLY) : (crc_next >> 1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_reg <= tpg_pkg::CRC_INIT;
		end else if (bs.init_crc) begin
			crc_reg <= tpg_pkg::CRC_INIT;
		end else if (bs.step_crc) begin
			crc_reg <= crc_next;
		end
	end

	assign bs.crc = crc_reg;
endmodule : fcs_crc
`default_nettype wire

// >>> hdl/prbs_bytes.sv
`default_nettype none
module prbs_bytes (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Byte steps
	byte_step_if.prbs_unit bs
);
	logic [14:0] lfsr_reg;
	logic [14:0] lfsr_next;

	// x^15 + x^14 + 1, eight shifts per byte
	always_comb begin
		lfsr_next = lfsr_reg;
		for (int i = 0; i < 8; i++) begin
			lfsr_next = {lfsr_next[13:0], lfsr_next[14] ^ lfsr_next[13]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_reg <= tpg_pkg::PRBS_SEED;
		end else if (bs.init_prbs) begin
			lfsr_reg <= tpg_pkg::PRBS_SEED;
		end else if (bs.step_prbs) begin
			lfsr_reg <= lfsr_next;
		end
	end

	assign bs.prbs = lfsr_reg[7:0];
endmodule : prbs_bytes
`default_nettype wire

// >>> tb/test_packet_gen_assertions.sv
`default_nettype none
module test_packet_gen_assertions #(
	parameter int PKT_BYTES = 60
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [15:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Streams
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_first,
	input wire logic tx_last,
	input wire logic [7:0] tx_data,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic da_done,
	input wire logic da_match,
	// Generator state
	input wire logic gen_busy,
	input wire logic gen_done
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	int unsigned pos;
	// Bytes taken so far in the current packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pos <= 0;
		else if (tx_valid && tx_ready)
			pos <= tx_first ? 1 : pos + 1;
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence addr_s;
		rx_valid && rx_sof ##1 (rx_valid && !rx_sof) [*5];
	endsequence
	a_ready_after_setup: assert property (setup_s |=> pready && penable)
		else $error("pready missing in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_misaligned: assert property (setup_s and paddr[1:0] != 2'h0 |=> pslverr && pready)
		else $error("misaligned access without error");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_first) && $stable(tx_last))
		else $error("stalled byte changed");
	a_gap_after_last: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*2])
		else $error("no gap after packet");
	a_last_position: assert property (tx_valid && tx_last |-> pos == PKT_BYTES + 3)
		else $error("last byte at wrong position");
	a_addr_compare: assert property (addr_s |=> da_done)
		else $error("no compare after six address bytes");
	a_match_in_done: assert property (da_match |-> da_done)
		else $error("match without compare");
	a_valid_busy: assert property (tx_valid |-> gen_busy)
		else $error("byte while not busy");
	a_done_idle: assert property (gen_done |-> !gen_busy)
		else $error("done while busy");
endmodule : test_packet_gen_assertions
`default_nettype wire

// >>> tb/test_packet_gen_tb.sv
`default_nettype none
module test_packet_gen_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PKT = 8;
	localparam int L = PKT + 4;
	// Register value after a frame's data plus a correct FCS
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, tx_valid, tx_first, tx_last, da_done, da_match, gen_busy, gen_done;
	logic [7:0] tx_data, rx_data = 8'h00;
	logic tx_ready = 1, stall = 0, rx_valid = 0, rx_sof = 0;
	logic [47:0] pat = 48'hC6B5A4938271;
	logic [9:0] q[$];
	logic [9:0] save[$];
	int fails = 0, compares = 0;
	always #2.5 pclk = ~pclk;
	// Stall on alternate cycles to exercise hold
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			q.push_back({tx_first, tx_last, tx_data});
		tx_ready <= stall ? ~tx_ready : 1'b1;
	end
	test_packet_gen #(.PKT_BYTES(PKT), .GAP_CYCLES(2)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
		.da_done(da_done), .da_match(da_match), .gen_busy(gen_busy), .gen_done(gen_done));
	task wrap_up;
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			fails++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : chk
	// Reflected CRC-32 over one byte, checked through the residue, not the FCS bytes
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h000000, b};
		for (int k = 0; k < 8; k++)
			r = r[0] ? ((r >> 1) ^ tpg_pkg::CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_step
	function automatic logic [15:0] ad(input logic [15:0] idx);
		return {idx[13:0], 2'b00};
	endfunction : ad
	task apb(input logic wr, input logic [15:0] a, input logic [15:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			fails++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rchk(input logic [15:0] idx, input logic [15:0] e);
		apb(0, ad(idx), 16'h0000);
		chk(rd === {16'h0000, e} && er === 1'b0, "register read");
	endtask : rchk
	task wait_idle(input int n);
		int k;
		for (k = 0; k < n && gen_busy !== 1'b0; k++)
			@(posedge pclk);
		if (gen_busy !== 1'b0) begin
			fails++;
			wrap_up();
		end
	endtask : wait_idle
	task start;
		apb(1, ad(tpg_pkg::IDX_GEN_CTRL), 16'h0001);
		@(posedge pclk);
		chk(gen_busy === 1'b1, "start busy");
		// First byte is loaded one cycle after busy rises
		@(posedge pclk);
		chk(tx_valid === 1'b1 && tx_first === 1'b1, "first byte");
	endtask : start
	task regs;
		int i;
		for (i = 0; i < 7; i++)
			rchk(tpg_pkg::IDX_GEN_CFG + i, i == 0 ? 16'h5511 : 16'h0000);
		for (i = 1; i < 7; i++)
			apb(1, ad(tpg_pkg::IDX_GEN_CFG + i), 16'h1357 * i);
		for (i = 1; i < 7; i++)
			rchk(tpg_pkg::IDX_GEN_CFG + i, 16'h1357 * i);
		for (i = 0; i < 3; i++)
			apb(1, ad(tpg_pkg::IDX_PAT_LOW + i), pat[16*i +: 16]);
		pstrb <= 4'h2;
		apb(1, ad(tpg_pkg::IDX_DM_LOW), 16'hAAAA);
		pstrb <= 4'hF;
		rchk(tpg_pkg::IDX_DM_LOW, 16'hAA5C);
		apb(0, ad(tpg_pkg::IDX_GEN_CFG) | 16'h0001, 16'h0000);
		chk(er === 1'b1 && rd === 32'h00000000, "misaligned access");
		apb(0, ad(16'h0700), 16'h0000);
		chk(er === 1'b1, "unmapped access");
	endtask : regs
	task da(input logic [47:0] v, input logic e);
		int k;
		for (k = 0; k < 6; k++) begin
			@(posedge pclk);
			rx_valid <= 1;
			rx_sof <= k == 0;
			rx_data <= v[8*k +: 8];
		end
		@(posedge pclk);
		rx_valid <= 0;
		rx_data <= ~rx_data;
		@(posedge pclk);
		chk(da_done === 1'b1 && da_match === e, "address compare");
		apb(0, ad(tpg_pkg::IDX_GEN_STATUS), 16'h0000);
		chk(rd[0] === e, "compare status");
	endtask : da
	task check_q(input logic [15:0] cfg);
		int j, i, n;
		logic [7:0] e;
		logic [31:0] c;
		n = cfg[5:3] > 6 ? 6 : cfg[5:3];
		c = tpg_pkg::CRC_INIT;
		for (j = 0; j < q.size(); j++) begin
			i = j % L;
			if (i == 0)
				c = tpg_pkg::CRC_INIT;
			c = crc_step(c, q[j][7:0]);
			if (i == L - 1)
				chk(c === CRC_RESIDUE, "frame check sequence");
			e = i < n ? pat[8*i +: 8] : cfg[7:6] == 2'h0 ? 8'(i - n) : cfg[15:8];
			chk(q[j][9] === (i == 0) && q[j][8] === (i == L - 1), "frame marks");
			if (i < PKT && cfg[7:6] < 2)
				chk(q[j][7:0] === e, "payload byte");
		end
	endtask : check_q
	task burst(input logic [15:0] cfg, input int npk);
		apb(1, ad(tpg_pkg::IDX_GEN_CFG), cfg);
		q.delete();
		start();
		wait_idle(npk * (L + 10) * 3 + 50);
		chk(q.size() === npk * L, "packet count");
		check_q(cfg);
		apb(0, ad(tpg_pkg::IDX_GEN_STATUS), 16'h0000);
		chk(rd[12:11] === 2'b10, "done status");
	endtask : burst
	task prbs_modes;
		int j;
		burst(16'h0080, 1);
		save = q;
		burst(16'h00C0, 1);
		chk(q.size() == save.size(), "random modes differ");
		for (j = 0; j < save.size(); j++)
			chk(q[j] === save[j], "random modes differ");
	endtask : prbs_modes
	task reset_mid;
		presetn <= 0;
		@(posedge pclk);
		chk(gen_busy === 1'b0 && gen_done === 1'b0 && tx_valid === 1'b0, "reset outputs");
		presetn <= 1;
		rchk(tpg_pkg::IDX_GEN_CFG, 16'h5511);
		rchk(tpg_pkg::IDX_PAT_LOW, 16'h0000);
		rchk(tpg_pkg::IDX_GEN_STATUS, 16'h0000);
	endtask : reset_mid
	task continuous;
		apb(1, ad(tpg_pkg::IDX_GEN_CFG), 16'h3307);
		q.delete();
		start();
		repeat (5 * L) @(posedge pclk);
		apb(1, ad(tpg_pkg::IDX_GEN_CTRL), 16'h0002);
		wait_idle(4 * L);
		chk(q.size() % L == 0 && q.size() >= 3 * L, "continuous run");
		check_q(16'h3307);
		apb(0, ad(tpg_pkg::IDX_GEN_STATUS), 16'h0000);
		chk(rd[12:11] === 2'b00, "stop leaves no done");
	endtask : continuous
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		regs();
		for (int i = 0; i < 3; i++)
			apb(1, ad(tpg_pkg::IDX_DM_LOW + i), 16'h3344 + 16'h1111 * i);
		da(48'h556644553344, 1);
		da(48'h547744553344, 0);
		burst(16'h0030, 1);
		stall <= 1;
		burst(16'hA579, 10);
		stall <= 0;
		burst(16'h5512, 100);
		prbs_modes();
		continuous();
		reset_mid();
		wrap_up();
	end
	// Cuts a hang short at 400000 ns, well above the wait_idle budgets of all tests together
	initial begin
		#400000;
		fails++;
		wrap_up();
	end
endmodule : test_packet_gen_tb
bind test_packet_gen test_packet_gen_assertions #(.PKT_BYTES(PKT_BYTES)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first),
	.tx_last(tx_last), .tx_data(tx_data), .rx_valid(rx_valid), .rx_sof(rx_sof),
	.da_done(da_done), .da_match(da_match), .gen_busy(gen_busy), .gen_done(gen_done));
`default_nettype wire
